//--- amcr_consts.vh
// constants for the audio mixer control register bank
`ifndef AMCR_CONSTS_VH
`define AMCR_CONSTS_VH
`define AMCR_SEL_INPUT   3'h0
`define AMCR_SEL_CENTER  3'h1
`define AMCR_SEL_LEFT    3'h2
`define AMCR_SEL_RIGHT   3'h3
`define AMCR_SEL_OUTPUT  3'h4
`define AMCR_SEL_GLOBAL  3'h5
`define AMCR_RST_INPUT   5'h10
`define AMCR_RST_LEVEL   5'h1f
`define AMCR_RST_OUTPUT  5'h08
`define AMCR_RST_GLOBAL  5'h03
`define AMCR_GL_PWR      4
`define AMCR_GL_BOOST6   3
`define AMCR_GL_MUTE     2
`define AMCR_GL_SPREAD   1
`define AMCR_GL_SUM      0
`define AMCR_IN_BOOST20  4
`define AMCR_OUT_CBOOST  4
`define AMCR_ROUTE_MUTE  4'hf
`endif

//--- amcr_master_model.sv
// command byte source standing in for the bus master and serial engine
module amcr_master_model (
	input  wire        clk,
	output logic       byte_valid,
	output logic       byte_is_read,
	output logic [7:0] byte_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial byte_valid = 1'b0;
	initial byte_is_read = 1'b0;
	initial byte_data = 8'h00;
	// one-cycle byte pulse; afterwards the data lines show the inverse
	task automatic send(input logic [7:0] d, input logic rd);
		@(negedge clk);
		byte_valid = 1'b1;
		byte_is_read = rd;
		byte_data = d;
		@(negedge clk);
		byte_valid = 1'b0;
		byte_is_read = ~rd;
		byte_data = ~d;
	endtask
endmodule

//--- amcr_regs.v
// audio mixer control register bank with decoded mixer controls
`include "amcr_consts.vh"
// Behaviour
// - top three bits select register, low five stored
// - write-only bank; reads never drive data
// - soft shutdown keeps registers; hard shutdown reloads defaults
// - input 10000, levels 11111 after reset
// - output 01000, global 00011 after reset
// - input A boost bit selects 20dB gain
// - mapping code sets pair single-ended or differential
// - inputs summed into left, right, center
// - level codes mute or low gain steps
// - upper level codes finer steps; separate registers
// - center path boost adds 6dB
// - routing field selects 16 output modes
// - power bit zero gives low-power shutdown
// - global boost bit adds 6dB to inputs
// - input A 20dB overrides global boost
// - mute bit silences every output
// - spread modulation select bit
// - speaker sum in modes 7,8,12,13
module amcr_regs (
	input  wire        clk,
	input  wire        resetn,
	input  wire        ce,
	input  wire        hw_shutdown_n,
	input  wire        byte_valid,
	input  wire        byte_is_read,
	input  wire [7:0]  byte_data,
	output reg  [4:0]  input_routing_ctrl_q,
	output reg  [4:0]  center_level_ctrl_q,
	output reg  [4:0]  left_level_ctrl_q,
	output reg  [4:0]  right_level_ctrl_q,
	output reg  [4:0]  output_routing_ctrl_q,
	output reg  [4:0]  global_ctrl_q,
	output reg  [5:0]  pair_diff_q,
	output reg  [2:0]  left_sel_q,
	output reg  [2:0]  right_sel_q,
	output reg  [2:0]  center_sel_q,
	output reg  [1:0]  input_a_gain_q,
	output reg  [1:0]  input_bc_gain_q,
	output reg  [6:0]  left_atten_q,
	output reg  [6:0]  right_atten_q,
	output reg  [6:0]  center_atten_q,
	output reg  [3:0]  level_mute_q,
	output reg         center_path_boost_q,
	output reg  [11:0] route_mix_q,
	output reg  [3:0]  amp_enable_q,
	output reg         soft_powerdown_n_q,
	output reg         spread_modulation_sel_q,
	output reg         all_mute_q
);
	// output summary
	// register copies: the six stored command fields
	// pair_diff_q: per-pin differential flags, pair a first
	// left/right/center_sel_q: pairs a,b,c summed per signal
	// input gains: 0 plain, 1 six dB, 2 twenty dB
	// attenuation outputs: positive dB below full level
	// level_mute_q: which level codes are at mute
	// center_path_boost_q: extra gain on center path
	// route_mix_q: receiver, left, right, speaker mixes
	// amp_enable_q: amplifiers with a source and power
	// soft_powerdown_n_q: low while either shutdown holds
	// spread_modulation_sel_q: speaker modulation choice
	// all_mute_q: global mute or mute routing mode
	// hazards
	// writes are dropped while the pin is low
	// a wake reload beats a write in the same cycle
	// decoded outputs lag the registers by one edge

	// pin input synchroniser, first stage read only by second
	reg        hw_sync1_q;  // first stage
	reg        hw_sync2_q;  // second stage
	reg        hw_prev_q;   // previous synchronised level
	wire       hw_release;  // leaving hardware shutdown
	wire       wr_en;       // accepted write byte
	wire [2:0] sel;         // register selector
	wire [4:0] wdat;        // register contents

	assign sel        = byte_data[7:5];
	assign wdat       = byte_data[4:0];
	assign wr_en      = byte_valid & ~byte_is_read & hw_sync2_q;
	assign hw_release = hw_sync2_q & ~hw_prev_q;

	// attenuation in dB from a level code; 0 for mute code
	function [6:0] level_atten;
		input [4:0] code;
		begin
			// coarse 4dB steps at the bottom
			if (code[4:3] == 2'b00)
				level_atten = 7'd79 - {code[2:0], 2'b00};
			// 3dB steps
			else if (code[4:3] == 2'b01)
				level_atten = 7'd47 - ({4'd0, code[2:0]} * 7'd3);
			// 2dB steps
			else if (code[4:3] == 2'b10)
				level_atten = 7'd23 - {3'd0, code[2:0], 1'b0};
			// 1dB steps up to full level
			else
				level_atten = 7'd7 - {4'd0, code[2:0]};
			// mute code reports zero, flagged elsewhere
			if (code[3:0] == 4'd0 && code[4] == 1'b0)
				level_atten = 7'd0;
		end
	endfunction

	// synchronise the hardware shutdown pin
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hw_sync1_q <= 1'b0;
			hw_sync2_q <= 1'b0;
			hw_prev_q  <= 1'b0;
		end else if (ce) begin
			hw_sync1_q <= hw_shutdown_n;
			hw_sync2_q <= hw_sync1_q;
			hw_prev_q  <= hw_sync2_q;
		end
	end

	// register bank: defaults on reset or hardware wake, else writes
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			input_routing_ctrl_q  <= `AMCR_RST_INPUT;
			center_level_ctrl_q   <= `AMCR_RST_LEVEL;
			left_level_ctrl_q     <= `AMCR_RST_LEVEL;
			right_level_ctrl_q    <= `AMCR_RST_LEVEL;
			output_routing_ctrl_q <= `AMCR_RST_OUTPUT;
			global_ctrl_q         <= `AMCR_RST_GLOBAL;
		end else if (ce) begin
			if (hw_release) begin
				input_routing_ctrl_q  <= `AMCR_RST_INPUT;
				center_level_ctrl_q   <= `AMCR_RST_LEVEL;
				left_level_ctrl_q     <= `AMCR_RST_LEVEL;
				right_level_ctrl_q    <= `AMCR_RST_LEVEL;
				output_routing_ctrl_q <= `AMCR_RST_OUTPUT;
				global_ctrl_q         <= `AMCR_RST_GLOBAL;
			end else if (wr_en) begin
				// writes accepted also in soft shutdown
				case (sel)
					// input mapping and input A boost
					`AMCR_SEL_INPUT:  input_routing_ctrl_q  <= wdat;
					// center level
					`AMCR_SEL_CENTER: center_level_ctrl_q   <= wdat;
					// left level
					`AMCR_SEL_LEFT:   left_level_ctrl_q     <= wdat;
					// right level
					`AMCR_SEL_RIGHT:  right_level_ctrl_q    <= wdat;
					// output routing and center boost
					`AMCR_SEL_OUTPUT: output_routing_ctrl_q <= wdat;
					// power, boost, mute, modulation, sum
					`AMCR_SEL_GLOBAL: global_ctrl_q         <= wdat;
					default: begin
						// selectors 6 and 7 ignored
					end
				endcase
			end
		end
	end

	// combinational decode of mixer controls
	reg  [5:0]  diff_d;   // per-pin differential flags a1,a2,b1,b2,c1,c2
	reg  [2:0]  l_d;      // pairs a,b,c feeding left
	reg  [2:0]  r_d;      // pairs feeding right
	reg  [2:0]  m_d;      // pairs feeding center
	reg  [11:0] mix_d;    // receiver,lhp,rhp,spk each {l,r,m}
	reg  [3:0]  en_d;     // amplifier enables
	reg         split_d;  // mapping codes with split differential pairs
	wire [3:0]  map;      // input mapping code
	wire [3:0]  route;    // output routing code
	wire        spk_sum;  // speaker sum bit
	assign map     = input_routing_ctrl_q[3:0];
	assign route   = output_routing_ctrl_q[3:0];
	assign spk_sum = global_ctrl_q[`AMCR_GL_SUM];

	always @* begin
		diff_d = 6'd0;
		l_d    = 3'd0;
		r_d    = 3'd0;
		m_d    = 3'd0;
		split_d = (map == 4'h4) || (map == 4'h5) || (map == 4'ha) || (map == 4'hb);
		// bit2 pair a, bit1 pair b, bit0 pair c
		case (map)
			// all pairs stereo
			4'h0: begin l_d = 3'b111; r_d = 3'b111; end
			// pair c to center
			4'h1: begin l_d = 3'b110; r_d = 3'b110; m_d = 3'b001; end
			// pair b to center
			4'h2: begin l_d = 3'b101; r_d = 3'b101; m_d = 3'b010; end
			// pairs b and c to center
			4'h3: begin l_d = 3'b100; r_d = 3'b100; m_d = 3'b011; end
			// pair c into left, pair b into right
			4'h4: begin l_d = 3'b101; r_d = 3'b110; end
			// pair b into left, pair c into right
			4'h5: begin l_d = 3'b110; r_d = 3'b101; end
			// pair a to center
			4'h6: begin l_d = 3'b011; r_d = 3'b011; m_d = 3'b100; end
			// pairs a and c to center
			4'h7: begin l_d = 3'b010; r_d = 3'b010; m_d = 3'b101; end
			// pairs a and b to center
			4'h8: begin l_d = 3'b001; r_d = 3'b001; m_d = 3'b110; end
			// center only
			4'h9: begin m_d = 3'b110; end
			// pair a center, c left, b right
			4'ha: begin l_d = 3'b001; r_d = 3'b010; m_d = 3'b100; end
			// pair a center, b left, c right
			4'hb: begin l_d = 3'b010; r_d = 3'b001; m_d = 3'b100; end
			default: begin
				// undefined codes route nothing
				l_d = 3'b000;
			end
		endcase
		// differential pairs: those feeding center, or pairs b and c in 4,5,a,b
		diff_d[5:4] = {2{m_d[2]}};
		diff_d[3:2] = {2{m_d[1] | (split_d & (l_d[1] | r_d[1]))}};
		diff_d[1:0] = {2{m_d[0] | (split_d & (l_d[0] | r_d[0]))}};
		mix_d = 12'd0;
		// output routing; speaker takes right only when sum bit set
		case (route)
			// receiver center
			4'h1: mix_d[11:9] = 3'b001;
			// speaker center
			4'h2: mix_d[2:0]  = 3'b001;
			// headphones and speaker center
			4'h3: begin mix_d[8:6] = 3'b001; mix_d[5:3] = 3'b001; mix_d[2:0] = 3'b001; end
			// headphones center
			4'h4: begin mix_d[8:6] = 3'b001; mix_d[5:3] = 3'b001; end
			// receiver left plus right
			4'h6: mix_d[11:9] = 3'b110;
			// speaker stereo sum
			4'h7: mix_d[2:0]  = {1'b1, spk_sum, 1'b0};
			// stereo headphones with speaker
			4'h8: begin mix_d[8:6] = 3'b100; mix_d[5:3] = 3'b010; mix_d[2:0] = {1'b1, spk_sum, 1'b0}; end
			// stereo headphones only
			4'h9: begin mix_d[8:6] = 3'b100; mix_d[5:3] = 3'b010; end
			// receiver full mix
			4'hb: mix_d[11:9] = 3'b111;
			// speaker full mix
			4'hc: mix_d[2:0]  = {1'b1, spk_sum, 1'b1};
			// headphones with center, speaker full mix
			4'hd: begin mix_d[8:6] = 3'b101; mix_d[5:3] = 3'b011; mix_d[2:0] = {1'b1, spk_sum, 1'b1}; end
			// headphones with center only
			4'he: begin mix_d[8:6] = 3'b101; mix_d[5:3] = 3'b011; end
			// modes 0, 5, 10 off; 15 mute
			default: mix_d = 12'd0;
		endcase
		en_d = {|mix_d[11:9], |mix_d[8:6], |mix_d[5:3], |mix_d[2:0]};
	end

	// registered decoded controls
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pair_diff_q             <= 6'd0;
			left_sel_q              <= 3'd0;
			right_sel_q             <= 3'd0;
			center_sel_q            <= 3'd0;
			input_a_gain_q          <= 2'd0;
			input_bc_gain_q         <= 2'd0;
			left_atten_q            <= 7'd0;
			right_atten_q           <= 7'd0;
			center_atten_q          <= 7'd0;
			level_mute_q            <= 4'hf;
			center_path_boost_q     <= 1'b0;
			route_mix_q             <= 12'd0;
			amp_enable_q            <= 4'd0;
			soft_powerdown_n_q      <= 1'b0;
			spread_modulation_sel_q <= 1'b0;
			all_mute_q              <= 1'b1;
		end else if (ce) begin
			pair_diff_q  <= diff_d;
			left_sel_q   <= l_d;
			right_sel_q  <= r_d;
			center_sel_q <= m_d;
			// gain code 0:0dB 1:6dB 2:20dB
			if (input_routing_ctrl_q[`AMCR_IN_BOOST20])
				input_a_gain_q <= 2'd2;
			else
				input_a_gain_q <= {1'b0, global_ctrl_q[`AMCR_GL_BOOST6]};
			// pairs b and c only see the global boost
			input_bc_gain_q <= {1'b0, global_ctrl_q[`AMCR_GL_BOOST6]};
			// per-signal attenuation from level codes
			left_atten_q    <= level_atten(left_level_ctrl_q);
			right_atten_q   <= level_atten(right_level_ctrl_q);
			center_atten_q  <= level_atten(center_level_ctrl_q);
			level_mute_q    <= {1'b0, center_level_ctrl_q == 5'd0,
				left_level_ctrl_q == 5'd0, right_level_ctrl_q == 5'd0};
			// extra center gain
			center_path_boost_q <= output_routing_ctrl_q[`AMCR_OUT_CBOOST];
			// routing and power gating
			route_mix_q  <= mix_d;
			amp_enable_q <= en_d & {4{hw_sync2_q & global_ctrl_q[`AMCR_GL_PWR]}};
			soft_powerdown_n_q      <= global_ctrl_q[`AMCR_GL_PWR] & hw_sync2_q;
			spread_modulation_sel_q <= global_ctrl_q[`AMCR_GL_SPREAD];
			all_mute_q <= global_ctrl_q[`AMCR_GL_MUTE] | (route == `AMCR_ROUTE_MUTE);
		end
	end
endmodule

//--- amcr_regs_props.sv
// port assertions for the control register bank
module amcr_regs_chk (
	input wire       clk,
	input wire       resetn,
	input wire       ce,
	input wire       hw_shutdown_n,
	input wire       byte_valid,
	input wire       byte_is_read,
	input wire [7:0] byte_data,
	input wire [4:0] input_routing_ctrl_q,
	input wire [4:0] output_routing_ctrl_q,
	input wire [4:0] global_ctrl_q,
	input wire [1:0] input_a_gain_q,
	input wire [3:0] amp_enable_q,
	input wire       soft_powerdown_n_q,
	input wire       all_mute_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [3:0] hw_h_q; // shutdown pin history, keeps reloads out of write checks
	wire        hw_ok = &hw_h_q & hw_shutdown_n;
	wire [14:0] regs  = {input_routing_ctrl_q, output_routing_ctrl_q, global_ctrl_q};
	// shift in the pin level each edge
	always @(posedge clk or negedge resetn) begin
		if (!resetn) hw_h_q <= 4'h0;
		else hw_h_q <= {hw_h_q[2:0], hw_shutdown_n};
	end
	glob_write_a: assert property (ce && byte_valid && !byte_is_read && byte_data[7:5] == 3'h5 && hw_ok
		|=> global_ctrl_q == $past(byte_data[4:0])) else $error("global write not stored");
	read_refused_a: assert property (ce && byte_valid && byte_is_read |=> $stable(regs))
		else $error("read changed a register");
	bad_select_a: assert property (ce && byte_valid && byte_data[7:6] == 2'b11 |=> $stable(regs))
		else $error("unused selector changed a register");
	hw_reload_a: assert property ($rose(hw_shutdown_n) && ce |-> ##[1:4] regs == {5'h10, 5'h08, 5'h03})
		else $error("defaults not reloaded");
	a_gain_a: assert property (ce |=> input_a_gain_q ==
		($past(input_routing_ctrl_q[4]) ? 2'h2 : {1'b0, $past(global_ctrl_q[3])})) else $error("input A gain");
	power_off_a: assert property (ce && !global_ctrl_q[4] |=> amp_enable_q == 4'h0)
		else $error("amplifier on in soft shutdown");
	pwr_follow_a: assert property (ce && hw_ok |=> soft_powerdown_n_q == $past(global_ctrl_q[4]))
		else $error("power bit not followed");
	mute_follow_a: assert property (ce && !global_ctrl_q[2] ##1 ce && global_ctrl_q[2] |=> all_mute_q)
		else $error("mute bit not followed");
endmodule
bind amcr_regs amcr_regs_chk u_chk (.clk(clk), .resetn(resetn), .ce(ce), .hw_shutdown_n(hw_shutdown_n),
	.byte_valid(byte_valid), .byte_is_read(byte_is_read), .byte_data(byte_data),
	.input_routing_ctrl_q(input_routing_ctrl_q), .output_routing_ctrl_q(output_routing_ctrl_q),
	.global_ctrl_q(global_ctrl_q), .input_a_gain_q(input_a_gain_q), .amp_enable_q(amp_enable_q),
	.soft_powerdown_n_q(soft_powerdown_n_q), .all_mute_q(all_mute_q));

//--- audio_mixer_control_registers_bench.sv
// self-checking bench for the control register bank
module audio_mixer_control_registers_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, ce, hw_shutdown_n, byte_valid, byte_is_read, boost_q, pwr_q, spread_q, mute_q;
	logic [7:0] byte_data;
	logic [4:0] in_q, ctr_q, lft_q, rgt_q, out_q, gl_q;
	logic [1:0] a_gain, bc_gain;
	logic [6:0] l_att;
	logic [3:0] lmute, amp_en;
	logic [5:0] pdiff;
	logic [11:0] rmix;
	int bad_count, comparisons, cycles;
	// level code beside its attenuation
	logic [11:0] rows [9] = '{{5'd0, 7'd0}, {5'd1, 7'd75}, {5'd8, 7'd47}, {5'd9, 7'd44}, {5'd15, 7'd26},
		{5'd16, 7'd23}, {5'd23, 7'd9}, {5'd24, 7'd7}, {5'd31, 7'd0}};
	amcr_master_model m (.clk(clk), .byte_valid(byte_valid), .byte_is_read(byte_is_read), .byte_data(byte_data));
	amcr_regs DUT (.clk(clk), .resetn(resetn), .ce(ce), .hw_shutdown_n(hw_shutdown_n), .byte_valid(byte_valid),
		.byte_is_read(byte_is_read), .byte_data(byte_data), .input_routing_ctrl_q(in_q),
		.center_level_ctrl_q(ctr_q), .left_level_ctrl_q(lft_q), .right_level_ctrl_q(rgt_q),
		.output_routing_ctrl_q(out_q), .global_ctrl_q(gl_q), .pair_diff_q(pdiff), .left_sel_q(), .right_sel_q(),
		.center_sel_q(), .input_a_gain_q(a_gain), .input_bc_gain_q(bc_gain), .left_atten_q(l_att),
		.right_atten_q(), .center_atten_q(), .level_mute_q(lmute), .center_path_boost_q(boost_q),
		.route_mix_q(rmix), .amp_enable_q(amp_en), .soft_powerdown_n_q(pwr_q), .spread_modulation_sel_q(spread_q),
		.all_mute_q(mute_q));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// byte out, then one more edge so decoded outputs settle
	task automatic put(input logic [7:0] d, input logic rd);
		m.send(d, rd);
		@(negedge clk);
	endtask
	task automatic defaults();
		check("input", {3'h0, in_q}, 8'h10);
		check("levels", {ctr_q & lft_q & rgt_q}, 8'h1f);
		check("output", {3'h0, out_q}, 8'h08);
		check("global", {3'h0, gl_q}, 8'h03);
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 500) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		hw_shutdown_n = 1'b1;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		defaults();
		check("diff", {2'h0, pdiff}, 8'h00);
		check("mixhi", {4'h0, rmix[11:8]}, 8'h01);
		check("mixlo", rmix[7:0], 8'h16);
		foreach (rows[i]) begin
			put({3'h2, rows[i][11:7]}, 1'b0);
			check("left", {3'h0, lft_q}, {3'h0, rows[i][11:7]});
			check("atten", {1'b0, l_att}, {1'b0, rows[i][6:0]});
			check("lmute", {7'h0, lmute[1]}, {7'h0, rows[i][11:7] == 5'h0});
		end
		check("right", {3'h0, rgt_q}, 8'h1f);
		put(8'hba, 1'b0);
		check("flags", {4'h0, pwr_q, spread_q, mute_q, 1'b0}, 8'h0c);
		check("gains", {4'h0, a_gain, bc_gain}, 8'h09);
		put(8'h00, 1'b0);
		check("again", {6'h0, a_gain}, 8'h01);
		put(8'h04, 1'b0);
		check("diff4", {2'h0, pdiff}, 8'h0f);
		put(8'ha0, 1'b1);
		put(8'he5, 1'b0);
		check("kept", {3'h0, gl_q}, 8'h1a);
		put(8'h9e, 1'b0);
		check("cboost", {7'h0, boost_q}, 8'h01);
		put(8'ha4, 1'b0);
		put(8'h47, 1'b0);
		check("soft", {lft_q, mute_q, amp_en[1:0]}, 8'h3c);
		hw_shutdown_n = 1'b0;
		repeat (3) @(negedge clk);
		put(8'hbf, 1'b0);
		check("hard", {3'h0, gl_q}, 8'h04);
		hw_shutdown_n = 1'b1;
		repeat (6) @(negedge clk);
		defaults();
		complete_run();
	end
endmodule
